// file: bench/saxu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module saxu_core_model (
  input wire logic mclk,
  input wire logic in_service,
  input wire logic irq_segment_save_enable,
  output var saxu_pkg::saxu_core_s core
);
  import saxu_pkg::*;
  initial core = '0;
  // one-cycle pulse: 0 entry, 1 return, 2 far load
  // a return pulse is handled by the kind of the latest entry, not of the one that opened it
  task automatic pulse(input int k, input logic [5:0] s);
    @(posedge mclk) #1 core.irq_ack = k == 0;
    core.iret = k == 1;
    // far load withheld inside a compat service routine
    core.far_load = k == 2 && !(in_service && !irq_segment_save_enable);
    core.far_seg = s;
    core.pop_seg = s;
    @(posedge mclk) #1 core = '0;
  endtask
endmodule
`default_nettype wire

// file: bench/saxu_properties.sv
`timescale 1ns/1ps
`default_nettype none
module saxu_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire saxu_pkg::saxu_regreq_s reg_req,
  input wire saxu_pkg::saxu_core_s core,
  input wire saxu_pkg::saxu_acc_e acc,
  input wire logic [15:0] vaddr,
  input wire logic [21:0] paddr,
  input wire logic push_code_segment,
  input wire logic in_service,
  input wire logic page_reg_remap,
  input wire logic irq_segment_save_enable,
  input wire logic port_sel,
  input wire logic [1:0] port_idx
);
  import saxu_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  push_save_a: assert property (core.irq_ack && irq_segment_save_enable |=> push_code_segment)
    else $error("no push");
  push_none_a: assert property (core.irq_ack && !irq_segment_save_enable |=> !push_code_segment)
    else $error("bad push");
  push_cause_a: assert property (push_code_segment |-> $past(core.irq_ack))
    else $error("stray push");
  entry_mode_a: assert property (core.irq_ack |=> in_service)
    else $error("no entry");
  code_low_a: assert property (acc == SAXU_ACC_CODE |-> paddr[15:0] == vaddr)
    else $error("code low bits");
  data_low_a: assert property (acc == SAXU_ACC_DATA |-> paddr[13:0] == vaddr[13:0])
    else $error("data low bits");
  port_hit_a: assert property (reg_req.re && page_reg_remap && reg_req.page == MMU_PAGE &&
    reg_req.addr[7:2] == 6'h3c |-> port_sel && port_idx == reg_req.addr[1:0]) else $error("port map");
  data_same_a: assert property (core.irq_ack && acc == SAXU_ACC_DATA && !reg_req.we |=>
    acc != SAXU_ACC_DATA || $changed(vaddr) || $stable(paddr)) else $error("data moved");
endmodule
`default_nettype wire

// file: bench/saxu_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module saxu_top_bench;
  import saxu_pkg::*;
  logic mclk = 0, rst_n = 0, dma_segment_select = 0;
  logic reg_hit, push_code_segment, in_service, page_reg_remap, irq_segment_save_enable, port_sel;
  logic [7:0] reg_rdata;
  logic [1:0] port_idx;
  logic [5:0] push_seg;
  logic [15:0] vaddr = 0;
  logic [21:0] paddr;
  saxu_regreq_s reg_req = '0;
  saxu_core_s core;
  saxu_acc_e acc = SAXU_ACC_CODE;
  int miscompares = 0, checks = 0;
  saxu_top u_saxu_top (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .core(core),
    .acc(acc),
    .vaddr(vaddr),
    .dma_segment_select(dma_segment_select),
    .paddr(paddr),
    .push_code_segment(push_code_segment),
    .push_seg(push_seg),
    .in_service(in_service),
    .page_reg_remap(page_reg_remap),
    .irq_segment_save_enable(irq_segment_save_enable),
    .port_sel(port_sel),
    .port_idx(port_idx)
  );
  saxu_core_model u_saxu_core_model (
    .mclk(mclk),
    .in_service(in_service),
    .irq_segment_save_enable(irq_segment_save_enable),
    .core(core)
  );
  initial forever #4 mclk = ~mclk;
  task automatic chk(input string n, input logic [21:0] e, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rq(input logic w, r, input logic [7:0] a, d);
    @(posedge mclk) #1 reg_req = '{w, r, MMU_PAGE, a, d};
  endtask
  task automatic xl(input saxu_acc_e a, input logic [15:0] v, input logic [21:0] e, input logic s = 0);
    @(posedge mclk) #1 acc = a;
    vaddr = v;
    dma_segment_select = s;
    #1 chk("paddr", e, paddr);
  endtask
  task automatic t_basic;
    rq(0, 1, CSR_ADDR, 8'h00);
    #1 chk("csr", 22'h0, {14'h0, reg_rdata});
    chk("csr hit", 22'h1, {21'h0, reg_hit});
    rq(0, 1, 8'h00, 8'h00);
    #1 chk("hit", 22'h0, {21'h0, reg_hit});
    xl(SAXU_ACC_CODE, 16'h1234, 22'h001234);
    rq(1, 0, ISEG_ADDR, 8'h2b);
    rq(1, 0, DSEG_ADDR, 8'h31);
    rq(0, 0, 8'h00, 8'h00);
    xl(SAXU_ACC_DMA, 16'h0400, 22'h2b0400);
    xl(SAXU_ACC_DMA, 16'h0400, 22'h310400, 1);
    xl(SAXU_ACC_VEC, 16'h0010, 22'h2b0010);
    $display("test basic done");
  endtask
  task automatic t_pages;
    for (int i = 0; i < 4; i++)
      rq(1, 0, DPR_BASE_ADDR + i[7:0], 8'ha0 + i[7:0]);
    rq(0, 0, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
      xl(SAXU_ACC_DATA, {i[1:0], 14'h02a5}, {8'ha0 + i[7:0], 14'h02a5});
    rq(1, 0, EXTENDED_MODE_REG_2_ADDR, 8'h20);
    rq(1, 0, 8'he2, 8'h5c);
    rq(0, 0, 8'h00, 8'h00);
    xl(SAXU_ACC_DATA, 16'h8001, 22'h170001);
    rq(0, 1, 8'hf1, 8'h00);
    #1 chk("port", 22'h5, {19'h0, port_sel, port_idx});
    rq(1, 0, EXTENDED_MODE_REG_2_ADDR, 8'h00);
    rq(0, 0, 8'h00, 8'h00);
    $display("test pages done");
  endtask
  task automatic t_compat;
    xl(SAXU_ACC_DATA, 16'h4abc, {8'ha1, 14'h0abc});
    u_saxu_core_model.pulse(0, 6'h00);
    chk("entry", 22'h1, {20'h0, push_code_segment, in_service});
    xl(SAXU_ACC_CODE, 16'h0100, 22'h2b0100);
    // code segment written only while unused by fetch
    rq(1, 0, CSR_ADDR, 8'h09);
    rq(0, 1, CSR_ADDR, 8'h00);
    #1 chk("csr", 22'h9, {14'h0, reg_rdata});
    // service routine borrows page 1, then puts it back
    rq(1, 0, 8'hf1, 8'h77);
    rq(0, 0, 8'h00, 8'h00);
    xl(SAXU_ACC_DATA, 16'h4abc, {8'h77, 14'h0abc});
    rq(1, 0, 8'hf1, 8'ha1);
    rq(0, 0, 8'h00, 8'h00);
    xl(SAXU_ACC_DATA, 16'h4abc, {8'ha1, 14'h0abc});
    u_saxu_core_model.pulse(1, 6'h00);
    xl(SAXU_ACC_CODE, 16'h0100, 22'h090100);
    chk("svc", 22'h0, {21'h0, in_service});
    $display("test compat done");
  endtask
  task automatic t_save;
    rq(1, 0, EXTENDED_MODE_REG_2_ADDR, 8'h40);
    rq(0, 0, 8'h00, 8'h00);
    xl(SAXU_ACC_DATA, 16'h4abc, {8'ha1, 14'h0abc});
    u_saxu_core_model.pulse(0, 6'h00);
    chk("push", 22'h49, {15'h0, push_code_segment, push_seg});
    xl(SAXU_ACC_CODE, 16'h0100, 22'h2b0100);
    u_saxu_core_model.pulse(2, 6'h12);
    xl(SAXU_ACC_CODE, 16'h0100, 22'h120100);
    u_saxu_core_model.pulse(1, 6'h09);
    xl(SAXU_ACC_CODE, 16'h0100, 22'h090100);
    chk("svc", 22'h0, {21'h0, in_service});
    $display("test save done");
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst_n = 1;
    t_basic;
    t_pages;
    t_compat;
    t_save;
    summarize;
  end
endmodule
bind saxu_top saxu_properties u_saxu_properties (
  .mclk(mclk),
  .rst_n(rst_n),
  .reg_req(reg_req),
  .core(core),
  .acc(acc),
  .vaddr(vaddr),
  .paddr(paddr),
  .push_code_segment(push_code_segment),
  .in_service(in_service),
  .page_reg_remap(page_reg_remap),
  .irq_segment_save_enable(irq_segment_save_enable),
  .port_sel(port_sel),
  .port_idx(port_idx)
);
`default_nettype wire

// file: common/saxu_pkg.sv
package saxu_pkg;

  // --------------------------------------------------------------------
  // address widths
  // --------------------------------------------------------------------
  localparam int VADDR_W = 16;
  localparam int PADDR_W = 22;
  localparam int SEG_W = 6;
  localparam int PAGE_W = 8;
  localparam int PAGE_SEL_HI = 15;
  localparam int PAGE_SEL_LO = 14;
  localparam int NUM_DPR = 4;

  // --------------------------------------------------------------------
  // register file locations (page 21, groups f and e)
  // --------------------------------------------------------------------
  localparam logic [7:0] MMU_PAGE = 8'h15;
  localparam logic [7:0] DPR_BASE_ADDR = 8'hf0;
  localparam logic [7:0] PORT_BASE_ADDR = 8'he0;
  localparam logic [7:0] EXTENDED_MODE_REG_2_ADDR = 8'hf6;
  localparam logic [7:0] CSR_ADDR = 8'hf4;
  localparam logic [7:0] ISEG_ADDR = 8'hf8;
  localparam logic [7:0] DSEG_ADDR = 8'hf9;

  // --------------------------------------------------------------------
  // extended mode register 2 fields and reset values
  // --------------------------------------------------------------------
  localparam int EXTENDED_MODE_REG_2_REMAP_BIT = 5;
  localparam int EXTENDED_MODE_REG_2_SAVE_BIT = 6;
  localparam logic [7:0] EXTENDED_MODE_REG_2_RESET = 8'h00;
  localparam logic [SEG_W-1:0] CSR_RESET = 6'h00;
  localparam logic [SEG_W-1:0] SEG_RESET = 6'h00;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SAXU_NORMAL = 3'b001,
    SAXU_IRQ_COMPAT = 3'b010,
    SAXU_IRQ_SAVED = 3'b100
  } saxu_mode_e;

  typedef enum logic [1:0] {
    SAXU_ACC_CODE = 2'h0,
    SAXU_ACC_DATA = 2'h1,
    SAXU_ACC_DMA = 2'h2,
    SAXU_ACC_VEC = 2'h3
  } saxu_acc_e;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } saxu_regreq_s;

  typedef struct packed {
    logic irq_ack;
    logic iret;
    logic far_load;
    logic [SEG_W-1:0] far_seg;
    logic [SEG_W-1:0] pop_seg;
  } saxu_core_s;

endpackage

// file: hdl/saxu_top.sv
// Overview of operation
// - code segment writable inside compat-mode service routine
// - remap bit swaps page regs with ports
// - compat mode fetches from interrupt segment
// - save mode pushes code segment, loads it
// - save mode return pops code segment
// - data mapping identical in service routines
// - dma segment picked by select bit
// - segment gives six upper address bits
// - vaddr 15:14 pick page register
// - code segment resets to zero
`timescale 1ns/1ps
`default_nettype none
module saxu_top #(
  parameter int NUM_PAGES = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire saxu_pkg::saxu_regreq_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire saxu_pkg::saxu_core_s core,
  input wire saxu_pkg::saxu_acc_e acc,
  input wire logic [saxu_pkg::VADDR_W-1:0] vaddr,
  input wire logic dma_segment_select,
  output logic [saxu_pkg::PADDR_W-1:0] paddr,
  output logic push_code_segment,
  output logic [saxu_pkg::SEG_W-1:0] push_seg,
  output logic in_service,
  output logic page_reg_remap,
  output logic irq_segment_save_enable,
  output logic port_sel,
  output logic [1:0] port_idx
);
  import saxu_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [SEG_W-1:0] code_segment_reg, next_code_segment_reg;
  logic [SEG_W-1:0] interrupt_segment_reg, next_interrupt_segment_reg;
  logic [SEG_W-1:0] dma_segment_reg, next_dma_segment_reg;
  logic [7:0] extended_mode_reg_2, next_extended_mode_reg_2;
  logic [NUM_PAGES*PAGE_W-1:0] data_page_reg, next_data_page_reg;
  saxu_mode_e mode, next_mode;
  logic [3:0] depth, next_depth;
  logic push_q, next_push_q;
  logic [SEG_W-1:0] push_seg_q, next_push_seg_q;

  logic on_page, dpr_base_hit, dpr_alt_hit;
  logic [1:0] dpr_idx;
  logic [SEG_W-1:0] fetch_seg, dma_seg;

  // --------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------
  assign on_page = reg_req.page == MMU_PAGE;
  assign page_reg_remap = extended_mode_reg_2[EXTENDED_MODE_REG_2_REMAP_BIT];
  assign irq_segment_save_enable = extended_mode_reg_2[EXTENDED_MODE_REG_2_SAVE_BIT];
  assign dpr_idx = reg_req.addr[1:0];
  // page registers sit at f0-f3 on page 21, or e0-e3 on any page when remapped
  assign dpr_base_hit = on_page && reg_req.addr[7:2] == DPR_BASE_ADDR[7:2];
  assign dpr_alt_hit = reg_req.addr[7:2] == PORT_BASE_ADDR[7:2];

  always_comb begin
    port_sel = 1'b0;
    port_idx = dpr_idx;
    if (page_reg_remap) begin
      port_sel = dpr_base_hit;
    end else begin
      port_sel = dpr_alt_hit;
    end
  end

  // --------------------------------------------------------------------
  // register writes and mode sequencing
  // --------------------------------------------------------------------
  always_comb begin
    next_code_segment_reg = code_segment_reg;
    next_interrupt_segment_reg = interrupt_segment_reg;
    next_dma_segment_reg = dma_segment_reg;
    next_extended_mode_reg_2 = extended_mode_reg_2;
    next_data_page_reg = data_page_reg;
    next_mode = mode;
    next_depth = depth;
    next_push_q = 1'b0;
    next_push_seg_q = push_seg_q;
    if (reg_req.we) begin
      if (on_page) begin
        unique case (reg_req.addr)
          // writable any time, but a far load, saved entry or saved return in the same cycle wins; software keeps it for safe windows
          CSR_ADDR: next_code_segment_reg = reg_req.wdata[SEG_W-1:0];
          ISEG_ADDR: next_interrupt_segment_reg = reg_req.wdata[SEG_W-1:0];
          DSEG_ADDR: next_dma_segment_reg = reg_req.wdata[SEG_W-1:0];
          EXTENDED_MODE_REG_2_ADDR: next_extended_mode_reg_2 = reg_req.wdata;
          default: ;
        endcase
      end
      if (page_reg_remap ? dpr_alt_hit : dpr_base_hit) begin
        next_data_page_reg[dpr_idx*PAGE_W +: PAGE_W] = reg_req.wdata;
      end
    end
    if (core.far_load) begin
      next_code_segment_reg = core.far_seg;
    end
    if (core.irq_ack) begin
      if (irq_segment_save_enable) begin
        next_push_q = 1'b1;
        next_push_seg_q = code_segment_reg;
        next_code_segment_reg = interrupt_segment_reg;
        next_mode = SAXU_IRQ_SAVED;
      end else begin
        next_mode = SAXU_IRQ_COMPAT;
      end
      next_depth = depth + 4'h1;
    end else if (core.iret) begin
      if (mode == SAXU_IRQ_SAVED) begin
        next_code_segment_reg = core.pop_seg;
      end
      next_depth = (depth == 4'h0) ? 4'h0 : depth - 4'h1;
      if (depth <= 4'h1) begin
        next_mode = SAXU_NORMAL;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_segment_reg <= CSR_RESET;
      interrupt_segment_reg <= SEG_RESET;
      dma_segment_reg <= SEG_RESET;
      extended_mode_reg_2 <= EXTENDED_MODE_REG_2_RESET;
      data_page_reg <= '0;
      mode <= SAXU_NORMAL;
      depth <= 4'h0;
      push_q <= 1'b0;
      push_seg_q <= SEG_RESET;
    end else begin
      code_segment_reg <= next_code_segment_reg;
      interrupt_segment_reg <= next_interrupt_segment_reg;
      dma_segment_reg <= next_dma_segment_reg;
      extended_mode_reg_2 <= next_extended_mode_reg_2;
      data_page_reg <= next_data_page_reg;
      mode <= next_mode;
      depth <= next_depth;
      push_q <= next_push_q;
      push_seg_q <= next_push_seg_q;
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  always_comb begin
    reg_rdata = 8'h00;
    reg_hit = 1'b0;
    if (reg_req.re) begin
      if (page_reg_remap ? dpr_alt_hit : dpr_base_hit) begin
        reg_rdata = data_page_reg[dpr_idx*PAGE_W +: PAGE_W];
        reg_hit = 1'b1;
      end else if (on_page) begin
        reg_hit = 1'b1;
        unique case (reg_req.addr)
          CSR_ADDR: reg_rdata = {2'h0, code_segment_reg};
          ISEG_ADDR: reg_rdata = {2'h0, interrupt_segment_reg};
          DSEG_ADDR: reg_rdata = {2'h0, dma_segment_reg};
          EXTENDED_MODE_REG_2_ADDR: reg_rdata = extended_mode_reg_2;
          default: reg_hit = 1'b0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // address extension
  // --------------------------------------------------------------------
  assign fetch_seg = (mode == SAXU_IRQ_COMPAT) ? interrupt_segment_reg : code_segment_reg;
  assign dma_seg = dma_segment_select ? dma_segment_reg : interrupt_segment_reg;
  assign push_code_segment = push_q;
  assign push_seg = push_seg_q;
  assign in_service = mode != SAXU_NORMAL;

  saxu_xlate u_xlate (
    .acc(acc),
    .vaddr(vaddr),
    .fetch_seg(fetch_seg),
    .vec_seg(interrupt_segment_reg),
    .dma_seg(dma_seg),
    .pages(data_page_reg[NUM_DPR*PAGE_W-1:0]),
    .paddr(paddr)
  );
endmodule
`default_nettype wire

// file: hdl/saxu_xlate.sv
`timescale 1ns/1ps
`default_nettype none
module saxu_xlate (
  input wire saxu_pkg::saxu_acc_e acc,
  input wire logic [saxu_pkg::VADDR_W-1:0] vaddr,
  input wire logic [saxu_pkg::SEG_W-1:0] fetch_seg,
  input wire logic [saxu_pkg::SEG_W-1:0] vec_seg,
  input wire logic [saxu_pkg::SEG_W-1:0] dma_seg,
  input wire logic [saxu_pkg::NUM_DPR*saxu_pkg::PAGE_W-1:0] pages,
  output logic [saxu_pkg::PADDR_W-1:0] paddr
);
  import saxu_pkg::*;

  logic [1:0] sel;
  logic [PAGE_W-1:0] page;

  assign sel = vaddr[PAGE_SEL_HI:PAGE_SEL_LO];
  assign page = pages[sel*PAGE_W +: PAGE_W];

  always_comb begin
    unique case (acc)
      SAXU_ACC_CODE: paddr = {fetch_seg, vaddr};
      SAXU_ACC_VEC: paddr = {vec_seg, vaddr};
      SAXU_ACC_DMA: paddr = {dma_seg, vaddr};
      SAXU_ACC_DATA: paddr = {page, vaddr[PAGE_SEL_LO-1:0]};
    endcase
  end
endmodule
`default_nettype wire
